// file: dsm_pkg.sv
package dsm_pkg;

// ----------------------------------------
// Command decoding
// ----------------------------------------
localparam logic [15:0] DSM_CMD_MASK = 16'h008F;
localparam logic [15:0] DSM_CMD_DISABLE = 16'h0000;
localparam logic [15:0] DSM_CMD_QSTOP = 16'h0002;
localparam logic [15:0] DSM_CMD_SHUTDOWN = 16'h0006;
localparam logic [15:0] DSM_CMD_SWITCH_ON = 16'h0007;
localparam logic [15:0] DSM_CMD_ENABLE = 16'h000F;
localparam int DSM_RESET_BIT = 7;
localparam logic [15:0] DSM_QS_AUTO_MAX = 16'h0003;

// ----------------------------------------
// Status word layout
// ----------------------------------------
localparam logic [15:0] DSM_STATUS_RST = 16'h0000;
localparam logic [15:0] DSM_STATE_MASK = 16'h03FF;
localparam int DSM_MODE_LSB = 10;
localparam int DSM_MODE_W = 6;
localparam logic [15:0] DSM_STS_INIT = 16'h0000;
localparam logic [15:0] DSM_STS_NOFAULT = 16'h0250;
localparam logic [15:0] DSM_STS_READY = 16'h0231;
localparam logic [15:0] DSM_STS_WAIT = 16'h0233;
localparam logic [15:0] DSM_STS_RUN = 16'h0237;
localparam logic [15:0] DSM_STS_QSTOP = 16'h0217;
localparam logic [15:0] DSM_STS_SOF = 16'h021F;
localparam logic [15:0] DSM_STS_FAULT = 16'h0218;

typedef enum logic [2:0] {
	DSM_INIT,
	DSM_NOFAULT,
	DSM_READY,
	DSM_WAIT,
	DSM_RUN,
	DSM_QSTOP,
	DSM_SOF,
	DSM_FAULT
} dsm_state_t;

function automatic logic [15:0] dsm_pattern(dsm_state_t s);
	logic [15:0] p;
	p = DSM_STS_INIT;
	case (s)
		DSM_NOFAULT: p = DSM_STS_NOFAULT;
		DSM_READY: p = DSM_STS_READY;
		DSM_WAIT: p = DSM_STS_WAIT;
		DSM_RUN: p = DSM_STS_RUN;
		DSM_QSTOP: p = DSM_STS_QSTOP;
		DSM_SOF: p = DSM_STS_SOF;
		DSM_FAULT: p = DSM_STS_FAULT;
		default: p = DSM_STS_INIT;
	endcase
	return p;
endfunction
endpackage

// file: dsm_if.sv
`timescale 1ns/1ns
interface dsm_if;
	import dsm_pkg::*;
	logic cmd_b7;
	logic b7_rise;
	logic b7_held;
	dsm_state_t st;
	logic wr_req;
	logic wr_run_mod;
	logic wr_allow;
	modport top (output cmd_b7, output st, output wr_req,
		output wr_run_mod, input b7_rise, input b7_held,
		input wr_allow);
	modport edg (input cmd_b7, output b7_rise, output b7_held);
	modport perm (input st, input wr_req, input wr_run_mod,
		output wr_allow);
endinterface

// file: dsm_edge.sv
`timescale 1ns/1ns
module dsm_edge (
	input wire logic clk_i,
	input wire logic rst_n_i,
	dsm_if.edg lnk
);
	logic prev_q;

	// Starts high so a level already high at reset is no edge.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			prev_q <= 1'b1;
		end else begin
			prev_q <= lnk.cmd_b7;
		end
	end

	assign lnk.b7_rise = lnk.cmd_b7 & ~prev_q;
	assign lnk.b7_held = lnk.cmd_b7;
endmodule

// file: dsm_perm.sv
`timescale 1ns/1ns
module dsm_perm
	import dsm_pkg::*;
(
	dsm_if.perm lnk
);
	always_comb begin
		case (lnk.st)
			DSM_INIT: lnk.wr_allow = 1'b0;
			DSM_RUN, DSM_QSTOP, DSM_SOF: begin
				lnk.wr_allow = lnk.wr_run_mod;
			end
			DSM_FAULT: lnk.wr_allow = 1'b1;
			default: lnk.wr_allow = 1'b1;
		endcase
	end
endmodule

// file: dsm_top.sv
`timescale 1ns/1ns
module dsm_top
	import dsm_pkg::*;
#(
	parameter int OPT_W = 16
) (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic [15:0] command_word_object_i,
	input wire logic [OPT_W-1:0] quick_stop_option_code_i,
	input wire logic init_done_i,
	input wire logic init_err_i,
	input wire logic fault_i,
	input wire logic stop_done_i,
	input wire logic [DSM_MODE_W-1:0] mode_status_i,
	input wire logic param_wr_i,
	input wire logic param_run_mod_i,
	output logic [15:0] state_report_object_o,
	output logic drive_en_o,
	output logic param_wr_ok_o,
	output logic param_wr_rej_o
);
	// ----------------------------------------
	// Parameter checks
	// ----------------------------------------
	if (OPT_W < 3 || OPT_W > 16) begin : g_chk
		$error("Option code width must be 3 to 16 bits.");
	end

	// ----------------------------------------
	// Helpers and submodules
	// ----------------------------------------
	dsm_if lnk ();
	dsm_state_t st_q;
	dsm_state_t st_d;
	logic [15:0] sts_q;
	logic [15:0] sts_d;
	logic qs_stopped_q;
	logic qs_stopped_d;
	logic drive_en_q;
	logic ok_q;
	logic rej_q;
	logic [15:0] cmd_c;
	logic [15:0] opt_w;
	logic qs_auto;
	logic go;

	assign cmd_c = command_word_object_i & DSM_CMD_MASK;
	assign opt_w = 16'(quick_stop_option_code_i);
	assign qs_auto = (opt_w <= DSM_QS_AUTO_MAX);
	assign go = !fault_i && !lnk.b7_held;

	assign lnk.cmd_b7 = command_word_object_i[DSM_RESET_BIT];
	assign lnk.st = st_q;
	assign lnk.wr_req = param_wr_i;
	assign lnk.wr_run_mod = param_run_mod_i;

	dsm_edge u_edge (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.lnk(lnk)
	);

	dsm_perm u_perm (
		.lnk(lnk)
	);

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		st_d = st_q;
		qs_stopped_d = qs_stopped_q;
		case (st_q)
			DSM_INIT: begin
				if (init_err_i || fault_i) begin
					st_d = DSM_SOF;
				end else if (init_done_i) begin
					st_d = DSM_NOFAULT;
				end
			end
			DSM_SOF: begin
				if (stop_done_i) begin
					st_d = DSM_FAULT;
				end
			end
			DSM_FAULT: begin
				if (lnk.b7_rise) begin
					st_d = DSM_NOFAULT;
				end
			end
			DSM_QSTOP: begin
				if (fault_i) begin
					st_d = DSM_SOF;
				end else if (stop_done_i && qs_auto) begin
					st_d = DSM_NOFAULT;
				end else if (stop_done_i) begin
					qs_stopped_d = 1'b1;
				end else if (qs_stopped_q && go &&
					cmd_c == DSM_CMD_ENABLE) begin
					st_d = DSM_RUN;
				end
			end
			default: begin
				if (fault_i) begin
					st_d = DSM_SOF;
				end else if (!lnk.b7_held) begin
					case (st_q)
						DSM_NOFAULT: begin
							if (cmd_c == DSM_CMD_SHUTDOWN) begin
								st_d = DSM_READY;
							end
						end
						DSM_READY: begin
							if (cmd_c == DSM_CMD_SWITCH_ON) begin
								st_d = DSM_WAIT;
							end else if (cmd_c == DSM_CMD_DISABLE) begin
								st_d = DSM_NOFAULT;
							end
						end
						DSM_WAIT: begin
							if (cmd_c == DSM_CMD_ENABLE) begin
								st_d = DSM_RUN;
							end else if (cmd_c == DSM_CMD_SHUTDOWN) begin
								st_d = DSM_READY;
							end else if (cmd_c == DSM_CMD_DISABLE) begin
								st_d = DSM_NOFAULT;
							end
						end
						DSM_RUN: begin
							if (cmd_c == DSM_CMD_SWITCH_ON) begin
								st_d = DSM_WAIT;
							end else if (cmd_c == DSM_CMD_SHUTDOWN) begin
								st_d = DSM_READY;
							end else if (cmd_c == DSM_CMD_DISABLE) begin
								st_d = DSM_NOFAULT;
							end else if (cmd_c == DSM_CMD_QSTOP) begin
								st_d = DSM_QSTOP;
							end
						end
						default: st_d = st_q;
					endcase
				end
			end
		endcase
		if (st_d != DSM_QSTOP) begin
			qs_stopped_d = 1'b0;
		end
	end

	// ----------------------------------------
	// Status word
	// ----------------------------------------
	always_comb begin
		sts_d = dsm_pattern(st_d);
		if (st_d != DSM_INIT) begin
			sts_d[DSM_MODE_LSB +: DSM_MODE_W] = mode_status_i;
		end
	end

	// ----------------------------------------
	// State registers
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			st_q <= DSM_INIT;
			qs_stopped_q <= 1'b0;
		end else begin
			st_q <= st_d;
			qs_stopped_q <= qs_stopped_d;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			sts_q <= DSM_STATUS_RST;
		end else begin
			sts_q <= sts_d;
		end
	end

	// Only the moving states energize the power stage.
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			drive_en_q <= 1'b0;
		end else begin
			drive_en_q <= (st_d == DSM_RUN) || (st_d == DSM_QSTOP) ||
				(st_d == DSM_SOF);
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			ok_q <= 1'b0;
			rej_q <= 1'b0;
		end else begin
			ok_q <= lnk.wr_req && lnk.wr_allow;
			rej_q <= lnk.wr_req && !lnk.wr_allow;
		end
	end

	assign state_report_object_o = sts_q;
	assign drive_en_o = drive_en_q;
	assign param_wr_ok_o = ok_q;
	assign param_wr_rej_o = rej_q;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	AST_INIT_ZERO: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_INIT |-> sts_q == 16'h0000 && !drive_en_o
	) else $error("Initialization status not zero.");

	AST_INIT_DONE: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_INIT && init_done_i && !init_err_i && !fault_i
		|=> st_q == DSM_NOFAULT && (sts_q & 16'h03FF) == 16'h0250
	) else $error("Init did not reach no-fault.");

	AST_INIT_ERR: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_INIT && init_err_i |=> st_q == DSM_SOF
	) else $error("Init error did not stop upon fault.");

	AST_SHUTDOWN: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_NOFAULT && go && cmd_c == 16'h0006
		|=> st_q == DSM_READY && (sts_q & 16'h03FF) == 16'h0231
	) else $error("Shutdown from no-fault failed.");

	AST_SWITCH_ON: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_READY && go && cmd_c == 16'h0007
		|=> st_q == DSM_WAIT && (sts_q & 16'h03FF) == 16'h0233
	) else $error("Switch on from ready failed.");

	AST_ENABLE: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_WAIT && go && cmd_c == 16'h000F
		|=> st_q == DSM_RUN && (sts_q & 16'h03FF) == 16'h0237 &&
			drive_en_o
	) else $error("Enable from wait failed.");

	AST_RUN_TO_WAIT: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_RUN && go && cmd_c == 16'h0007
		|=> st_q == DSM_WAIT && !drive_en_o
	) else $error("Disable operation failed.");

	AST_WAIT_TO_READY: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_WAIT && go && cmd_c == 16'h0006
		|=> st_q == DSM_READY
	) else $error("Wait to ready failed.");

	AST_RUN_TO_READY: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_RUN && go && cmd_c == 16'h0006
		|=> st_q == DSM_READY && (sts_q & 16'h03FF) == 16'h0231
	) else $error("Run to ready failed.");

	AST_DISABLE_V: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(st_q == DSM_READY || st_q == DSM_WAIT || st_q == DSM_RUN) &&
			go && cmd_c == 16'h0000
		|=> st_q == DSM_NOFAULT && (sts_q & 16'h03FF) == 16'h0250
	) else $error("Disable voltage failed.");

	AST_QSTOP: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_RUN && go && cmd_c == 16'h0002
		|=> st_q == DSM_QSTOP && (sts_q & 16'h03FF) == 16'h0217 &&
			drive_en_o
	) else $error("Quick stop not entered.");

	AST_QS_AUTO: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_QSTOP && !fault_i && stop_done_i &&
			opt_w <= 16'h0003
		|=> st_q == DSM_NOFAULT && !drive_en_o
	) else $error("Quick stop did not end in no-fault.");

	AST_QS_HOLD: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_QSTOP && !fault_i && stop_done_i &&
			opt_w >= 16'h0005
		|=> st_q == DSM_QSTOP && qs_stopped_q
	) else $error("Quick stop did not hold.");

	AST_QS_RESUME: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_QSTOP && qs_stopped_q && !stop_done_i && go &&
			cmd_c == 16'h000F
		|=> st_q == DSM_RUN && (sts_q & 16'h03FF) == 16'h0237
	) else $error("Quick stop did not resume.");

	AST_FAULT_IN: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		fault_i && st_q != DSM_FAULT && st_q != DSM_SOF
		|=> st_q == DSM_SOF && (sts_q & 16'h03FF) == 16'h021F
	) else $error("Fault did not stop upon fault.");

	AST_SOF_END: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_SOF && stop_done_i
		|=> st_q == DSM_FAULT && (sts_q & 16'h03FF) == 16'h0218 &&
			!drive_en_o
	) else $error("Fault state not entered.");

	AST_FAULT_CLEAR: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_FAULT && !$past(command_word_object_i[7]) &&
			command_word_object_i[7]
		|=> st_q == DSM_NOFAULT && (sts_q & 16'h03FF) == 16'h0250
	) else $error("Fault reset edge ignored.");

	AST_FAULT_LEVEL: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_FAULT && $past(command_word_object_i[7]) &&
			command_word_object_i[7]
		|=> st_q == DSM_FAULT
	) else $error("Fault cleared by steady level.");

	AST_B7_MASK: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(st_q == DSM_NOFAULT || st_q == DSM_READY || st_q == DSM_WAIT ||
			st_q == DSM_RUN) && !fault_i && command_word_object_i[7]
		|=> $stable(st_q)
	) else $error("Command obeyed while bit 7 high.");

	AST_MODE_BITS: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q != DSM_INIT |-> sts_q[15:10] == $past(mode_status_i)
	) else $error("Mode status bits wrong.");

	AST_INIT_REJ: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_INIT && param_wr_i |=> param_wr_rej_o && !param_wr_ok_o
	) else $error("Write accepted during initialization.");

	AST_RUN_REJ: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(st_q == DSM_RUN || st_q == DSM_QSTOP || st_q == DSM_SOF) &&
			param_wr_i &&
			!param_run_mod_i
		|=> param_wr_rej_o
	) else $error("Locked parameter written while moving.");

	AST_FAULT_WR: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_FAULT && param_wr_i |=> param_wr_ok_o && !drive_en_o
	) else $error("Fault state refused write.");

	AST_NO_MATCH: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		st_q == DSM_READY && go && cmd_c == 16'h0002
		|=> $stable(st_q) && (sts_q & 16'h03FF) == 16'h0231
	) else $error("Unmatched command changed state.");

	AST_STS_MATCH: assert property (
		@(posedge clk_i) disable iff (!rst_n_i)
		(sts_q & 16'h03FF) == dsm_pattern(st_q)
	) else $error("Status does not match state.");
endmodule

// file: dsm_host.sv
`timescale 1ns/1ns
// ----------------------------------------
// Host controller model
// ----------------------------------------
module dsm_host (
	input wire logic clk_i,
	output logic [15:0] cmd_o
);
	initial cmd_o = 16'h0000;

	// Launches one whole control word just after a rising edge.
	task automatic send(input logic [15:0] w);
		cmd_o <= w;
	endtask

	// Keeps the last word on the line for a number of cycles.
	task automatic hold(input int n);
		repeat (n) @(posedge clk_i);
	endtask
endmodule

// file: dsm_top_tb.sv
`timescale 1ns/1ns
module dsm_top_tb;
	import dsm_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	wire [15:0] cmd;
	logic [15:0] qs_opt = 16'h0000;
	logic init_done_i = 1'b0;
	logic init_err_i = 1'b0;
	logic fault_i = 1'b0;
	logic stop_done_i = 1'b0;
	logic [5:0] mode_i = 6'h2A;
	logic param_wr_i = 1'b0;
	logic param_run_mod_i = 1'b0;
	logic [15:0] sts;
	logic drv;
	logic wok;
	logic wrej;
	int err_total = 0;
	int compares = 0;

	always #4 clk_i = ~clk_i;

	dsm_host u_host (.clk_i(clk_i), .cmd_o(cmd));

	dsm_top #(.OPT_W(16)) DUT (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.command_word_object_i(cmd),
		.quick_stop_option_code_i(qs_opt),
		.init_done_i(init_done_i),
		.init_err_i(init_err_i),
		.fault_i(fault_i),
		.stop_done_i(stop_done_i),
		.mode_status_i(mode_i),
		.param_wr_i(param_wr_i),
		.param_run_mod_i(param_run_mod_i),
		.state_report_object_o(sts),
		.drive_en_o(drv),
		.param_wr_ok_o(wok),
		.param_wr_rej_o(wrej)
	);

	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic print_verdict;
		if (err_total == 0 && compares > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		compares++;
		if (g !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, g);
			err_total++;
		end
	endtask

	// Applies a word and one-cycle events, then waits for the answer.
	task automatic step(input logic [15:0] w, input logic [3:0] ev);
		@(posedge clk_i);
		u_host.send(w);
		{init_done_i, init_err_i, fault_i, stop_done_i} <= ev;
		@(posedge clk_i);
		{init_done_i, init_err_i, fault_i, stop_done_i} <= 4'h0;
		#1;
	endtask

	task automatic st(input logic [15:0] p, input logic de);
		logic [15:0] e;
		e = (p == DSM_STS_INIT) ? 16'h0000 : {mode_i, p[9:0]};
		chk("status", e, sts);
		chk("drive_en", {15'h0000, de}, {15'h0000, drv});
	endtask

	task automatic pw(input logic rm, input logic ok);
		@(posedge clk_i);
		param_wr_i <= 1'b1;
		param_run_mod_i <= rm;
		@(posedge clk_i);
		param_wr_i <= 1'b0;
		#1;
		chk("wr_ok", {15'h0000, ok}, {15'h0000, wok});
		chk("wr_rej", {15'h0000, !ok}, {15'h0000, wrej});
	endtask

	task automatic rst(input int n);
		@(posedge clk_i);
		rst_n_i <= 1'b0;
		u_host.send(16'h0000);
		repeat (n) @(posedge clk_i);
		rst_n_i <= 1'b1;
		#1;
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_init_fault;
		rst(2);
		st(DSM_STS_INIT, 1'b0);
		pw(1'b1, 1'b0);
		step(16'h0080, 4'h4);
		st(DSM_STS_SOF, 1'b1);
		pw(1'b0, 1'b0);
		step(16'h0080, 4'h1);
		st(DSM_STS_FAULT, 1'b0);
		step(16'h0080, 4'h0);
		st(DSM_STS_FAULT, 1'b0);
		pw(1'b0, 1'b1);
		step(16'h0000, 4'h0);
		step(16'h0080, 4'h0);
		st(DSM_STS_NOFAULT, 1'b0);
	endtask

	task automatic t_walk;
		rst(2);
		step(16'h0000, 4'h8);
		st(DSM_STS_NOFAULT, 1'b0);
		pw(1'b0, 1'b1);
		step(16'h0007, 4'h0);
		st(DSM_STS_NOFAULT, 1'b0);
		step(16'h0006, 4'h0);
		st(DSM_STS_READY, 1'b0);
		step(16'h0002, 4'h0);
		st(DSM_STS_READY, 1'b0);
		step(16'h0007, 4'h0);
		st(DSM_STS_WAIT, 1'b0);
		step(16'h000F, 4'h0);
		st(DSM_STS_RUN, 1'b1);
		pw(1'b0, 1'b0);
		pw(1'b1, 1'b1);
		step(16'h0087, 4'h0);
		st(DSM_STS_RUN, 1'b1);
		step(16'h0007, 4'h0);
		st(DSM_STS_WAIT, 1'b0);
		step(16'h0006, 4'h0);
		st(DSM_STS_READY, 1'b0);
		step(16'h0007, 4'h0);
		u_host.hold(3);
		step(16'h000F, 4'h0);
		step(16'h0006, 4'h0);
		st(DSM_STS_READY, 1'b0);
		for (int d = 0; d < 3; d++) begin
			step(16'h0006, 4'h0);
			if (d > 0) step(16'h0007, 4'h0);
			if (d > 1) step(16'h000F, 4'h0);
			step(16'h0000, 4'h0);
			st(DSM_STS_NOFAULT, 1'b0);
		end
	endtask

	task automatic t_qstop;
		for (int o = 0; o < 8; o++) begin
			@(posedge clk_i);
			qs_opt <= 16'(o);
			mode_i <= 6'(o + 8);
			step(16'h0006, 4'h0);
			step(16'h0007, 4'h0);
			step(16'h000F, 4'h0);
			step(16'h0002, 4'h0);
			st(DSM_STS_QSTOP, 1'b1);
			pw(1'b0, 1'b0);
			step(16'h000F, 4'h0);
			st(DSM_STS_QSTOP, 1'b1);
			step(16'h000F, 4'h1);
			if (o <= 3) begin
				st(DSM_STS_NOFAULT, 1'b0);
			end else begin
				st(DSM_STS_QSTOP, 1'b1);
				step(16'h000F, 4'h0);
				st(DSM_STS_RUN, 1'b1);
			end
			step(16'h0000, 4'h0);
		end
	endtask

	task automatic t_fault;
		step(16'h0076, 4'h0);
		st(DSM_STS_READY, 1'b0);
		step(16'h0007, 4'h0);
		step(16'h000F, 4'h0);
		step(16'h000F, 4'h2);
		st(DSM_STS_SOF, 1'b1);
		step(16'h0006, 4'h0);
		st(DSM_STS_SOF, 1'b1);
		step(16'h0006, 4'h1);
		st(DSM_STS_FAULT, 1'b0);
		step(16'h0000, 4'h0);
		st(DSM_STS_FAULT, 1'b0);
		step(16'h0080, 4'h0);
		st(DSM_STS_NOFAULT, 1'b0);
		step(16'h0000, 4'h2);
		st(DSM_STS_SOF, 1'b1);
	endtask

	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial begin
		repeat (20) @(posedge clk_i);
		rst_n_i <= 1'b1;
		t_init_fault();
		t_walk();
		t_qstop();
		t_fault();
		print_verdict();
	end

	initial begin
		repeat (20000) @(posedge clk_i);
		$display("[ERR] watchdog expected done seen running");
		err_total++;
		print_verdict();
	end
endmodule
